// ---- rtl/nssf_pkg.sv ----
// Constants and carriers for the NAND status and strength feature host.
// Assumes a 100 MHz core clock and an asynchronous NAND target on pins.
package nssf_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_WL_NS = 50; // Strobe low time
	localparam int T_WH_NS = 30; // Strobe high time
	localparam int T_ADL_NS = 70; // Address to data input
	localparam int T_WHR_NS = 60; // Command to data output
	localparam int T_WB_NS = 100; // Last strobe to busy valid
	// Least times round up to whole cycles
	localparam logic [7:0] WL_CYC = 8'((T_WL_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WH_CYC = 8'((T_WH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ADL_CYC = 8'((T_ADL_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WB_CYC = 8'((T_WB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] BEAT_CYC = WL_CYC + WH_CYC;
	// Read data sampled late: two sync stages behind the pin
	localparam logic [7:0] CAP_CYC = WL_CYC + 8'h01;

	// ----------------------------------------------------------------
	// Device commands, features and status bits
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;
	localparam logic [7:0] FEAT_DRIVE = 8'h80;
	localparam logic [7:0] FEAT_PULLDOWN = 8'h81;
	localparam logic [7:0] STRENGTH_RST = 8'h00;
	localparam int SB_RDY = 6;

	// ----------------------------------------------------------------
	// Own register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ROW = 8'h04;
	localparam logic [7:0] REG_FEAT = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_PDATA = 8'h10;
	localparam logic [7:0] REG_SHADOW = 8'h14;
	localparam int CTRL_POLL = 3;
	localparam int CTRL_MULTI = 4;
	localparam int CTRL_OTP = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_ST70, OP_ST78, OP_SETF, OP_GETF, OP_RDMODE
	} nssf_op_t;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic read_strobe_n;
		logic io_oe_n;
		logic [7:0] io_out;
	} nssf_pins_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} nssf_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nssf_axi_rsp_t;

endpackage

// ---- rtl/nssf_host.sv ----
// Host sequencer for NAND status reads and drive strength features.
// Assumes AXI4-Lite master on core_clk; NAND pins are asynchronous.
//
// Notes on behaviour
// - Set features: EFh, feature address, four bytes; get returns four.
// - Host sends 00h to leave status and resume data output.
// - Single die target may use 70h after any command.
// - Multi-die interleaved work needs 78h; 70h causes contention.
// - 78h takes three row bytes and selects only that die.
// - 78h also enables output; 00h then data, 06h-E0h switches.
// - No 78h during power-on reset or one-time-programmable mode; only the OTP bit of the order word refuses it here.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module nssf_host (
	input wire logic core_clk, // 100 MHz core clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire nssf_pkg::nssf_axi_req_t axi_req, // AXI4-Lite requests
	output nssf_pkg::nssf_axi_rsp_t axi_rsp, // AXI4-Lite answers
	output nssf_pkg::nssf_pins_t pins, // NAND control and data out
	input wire logic [7:0] io_in, // NAND data lines in
	input wire logic rb_n // Ready/busy pin, low busy
);
	typedef enum logic [2:0] {
		S_IDLE, S_CMD, S_ADDR, S_WAIT, S_DIN, S_BUSY, S_DOUT, S_POLL
	} nssf_state_t;

	nssf_state_t st_q;
	nssf_pkg::nssf_op_t op_q;
	nssf_pkg::nssf_pins_t pins_q;
	logic [7:0] io_s1_q, io_s2_q, sr_q, drive_q, pull_q, faddr_q, cnt_q;
	logic [7:0] tw_q, byte_d;
	logic rb_s1_q, rb_s2_q, poll_q, multi_q, otp_q, err_q;
	logic [1:0] idx_q, code_q, bresp_q;
	logic [23:0] row_q;
	logic [31:0] pdata_q, rdata_q;
	logic awready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] rresp_q;
	logic wr_hit, start, refuse, beat_end, is_st, feat_ok;
	logic [7:0] waddr, raddr;
	logic [2:0] op_w;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Two stages; only the second stage is read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end else begin
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
			rb_s1_q <= rb_n;
			rb_s2_q <= rb_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign waddr = axi_req.awaddr[7:0];
	assign raddr = axi_req.araddr[7:0];
	assign wr_hit = awready_q;
	assign op_w = axi_req.wdata[2:0];
	// Feature address lives in FEAT, not in the order word
	assign feat_ok = faddr_q == nssf_pkg::FEAT_DRIVE ||
		faddr_q == nssf_pkg::FEAT_PULLDOWN;

	// Address and data taken together, one cycle after both valid
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= nssf_pkg::RESP_OKAY;
		end else begin
			awready_q <= axi_req.awvalid && axi_req.wvalid && !awready_q &&
				!bvalid_q;
			if (wr_hit) begin
				bvalid_q <= 1'b1;
				bresp_q <= (waddr > nssf_pkg::REG_SHADOW || waddr[1:0] != 2'h0) ?
					nssf_pkg::RESP_SLVERR : nssf_pkg::RESP_OKAY;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read mux; unmapped words read zero with SLVERR
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= nssf_pkg::RESP_OKAY;
		end else begin
			arready_q <= axi_req.arvalid && !arready_q && !rvalid_q;
			if (arready_q) begin
				rvalid_q <= 1'b1;
				rresp_q <= nssf_pkg::RESP_OKAY;
				unique case (raddr)
				nssf_pkg::REG_CTRL: rdata_q <= {26'h0, otp_q, multi_q, poll_q, op_q};
				nssf_pkg::REG_ROW: rdata_q <= {8'h00, row_q};
				nssf_pkg::REG_FEAT: rdata_q <= {22'h0, code_q, faddr_q};
				// Bit 2 is the synchronised busy pin level, not the ready bit of the selected die
				nssf_pkg::REG_STAT: rdata_q <= {16'h0, sr_q, 5'h0, rb_s2_q, err_q,
					st_q != S_IDLE};
				nssf_pkg::REG_PDATA: rdata_q <= pdata_q;
				nssf_pkg::REG_SHADOW: rdata_q <= {16'h0, pull_q, drive_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= nssf_pkg::RESP_SLVERR;
				end
				endcase
			end else if (rvalid_q && axi_req.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign axi_rsp = '{awready: awready_q, wready: awready_q, bvalid: bvalid_q,
		bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
		rresp: rresp_q};

	// ----------------------------------------------------------------
	// Orders from software
	// ----------------------------------------------------------------
	// 70h free on a single-die target
	// 70h refused on multi-die; 78h refused in OTP
	assign refuse = op_w > 3'h4 ||
		(op_w == 3'(nssf_pkg::OP_ST70) && axi_req.wdata[nssf_pkg::CTRL_MULTI]) ||
		(op_w == 3'(nssf_pkg::OP_ST78) && axi_req.wdata[nssf_pkg::CTRL_OTP]) ||
		((op_w == 3'(nssf_pkg::OP_SETF) || op_w == 3'(nssf_pkg::OP_GETF)) &&
		!feat_ok);
	assign start = wr_hit && waddr == nssf_pkg::REG_CTRL && st_q == S_IDLE &&
		!refuse;

	// Config held while an operation runs; writes then are dropped
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_q <= nssf_pkg::OP_ST70;
			poll_q <= 1'b0;
			multi_q <= 1'b0;
			otp_q <= 1'b0;
			err_q <= 1'b0;
			row_q <= 24'h00_0000;
			faddr_q <= nssf_pkg::FEAT_DRIVE;
			code_q <= 2'h0;
		end else if (wr_hit && st_q == S_IDLE) begin
			unique case (waddr)
			nssf_pkg::REG_CTRL: begin
				if (!refuse) begin
					op_q <= nssf_pkg::nssf_op_t'(op_w);
				end
				poll_q <= axi_req.wdata[nssf_pkg::CTRL_POLL];
				multi_q <= axi_req.wdata[nssf_pkg::CTRL_MULTI];
				otp_q <= axi_req.wdata[nssf_pkg::CTRL_OTP];
				err_q <= refuse;
			end
			nssf_pkg::REG_ROW: row_q <= axi_req.wdata[23:0];
			nssf_pkg::REG_FEAT: begin
				faddr_q <= axi_req.wdata[7:0];
				code_q <= axi_req.wdata[9:8];
			end
			default: ;
			endcase
		end else if (wr_hit && waddr == nssf_pkg::REG_CTRL) begin
			err_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------------------------------
	assign beat_end = cnt_q == nssf_pkg::BEAT_CYC - 8'h01;
	assign is_st = op_q == nssf_pkg::OP_ST70 || op_q == nssf_pkg::OP_ST78;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_IDLE;
			cnt_q <= 8'h00;
			idx_q <= 2'h0;
			tw_q <= 8'h00;
		end else begin
			// Held at zero in waits so the next beat gets its full strobe
			cnt_q <= (beat_end || st_q == S_IDLE || st_q == S_WAIT ||
				st_q == S_BUSY) ? 8'h00 : cnt_q + 8'h01;
			unique case (st_q)
			S_IDLE: if (start) begin
				st_q <= S_CMD;
				idx_q <= 2'h0;
			end
			// Read mode ends after its command byte
			S_CMD: if (beat_end) begin
				if (op_q == nssf_pkg::OP_RDMODE) begin
					st_q <= S_IDLE;
				end else if (op_q == nssf_pkg::OP_ST70) begin
					st_q <= S_WAIT;
					tw_q <= nssf_pkg::WHR_CYC;
				end else begin
					st_q <= S_ADDR;
				end
			end
			// Three row bytes for 78h, one feature address else
			S_ADDR: if (beat_end) begin
				if (op_q == nssf_pkg::OP_ST78 && idx_q != 2'h2) begin
					idx_q <= idx_q + 2'h1;
				end else begin
					idx_q <= 2'h0;
					st_q <= op_q == nssf_pkg::OP_GETF ? S_BUSY : S_WAIT;
					tw_q <= op_q == nssf_pkg::OP_SETF ? nssf_pkg::ADL_CYC :
						op_q == nssf_pkg::OP_GETF ? nssf_pkg::WB_CYC :
						nssf_pkg::WHR_CYC;
				end
			end
			S_WAIT: if (tw_q != 8'h00) begin
				tw_q <= tw_q - 8'h01;
			end else begin
				st_q <= op_q == nssf_pkg::OP_SETF ? S_DIN :
					poll_q ? S_POLL : S_DOUT;
			end
			// Four parameter bytes, then wait for the target
			S_DIN: if (beat_end) begin
				idx_q <= idx_q + 2'h1;
				if (idx_q == 2'h3) begin
					st_q <= S_BUSY;
					tw_q <= nssf_pkg::WB_CYC;
				end
			end
			// Hold off until busy pin shows ready again
			S_BUSY: if (tw_q != 8'h00) begin
				tw_q <= tw_q - 8'h01;
			end else if (rb_s2_q) begin
				st_q <= op_q == nssf_pkg::OP_GETF ? S_DOUT : S_IDLE;
			end
			S_DOUT: if (beat_end) begin
				idx_q <= idx_q + 2'h1;
				if (is_st || idx_q == 2'h3) begin
					st_q <= S_IDLE;
				end
			end
			// Read strobe held low; leave once ready shows
			S_POLL: if (cnt_q >= nssf_pkg::CAP_CYC && io_s2_q[nssf_pkg::SB_RDY]) begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end

	// Status taken every cycle in poll, else status or parameter bytes taken late in each read beat
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_q <= 8'h00;
			pdata_q <= 32'h0000_0000;
		end else if (st_q == S_POLL || (st_q == S_DOUT &&
			cnt_q == nssf_pkg::CAP_CYC)) begin
			if (is_st) begin
				sr_q <= io_s2_q;
			end else begin
				pdata_q[{idx_q, 3'h0} +: 8] <= io_s2_q;
			end
		end
	end

	// Shadows reset to full strength; set when done
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_q <= nssf_pkg::STRENGTH_RST;
			pull_q <= nssf_pkg::STRENGTH_RST;
		end else if (st_q == S_BUSY && op_q == nssf_pkg::OP_SETF &&
			tw_q == 8'h00 && rb_s2_q) begin
			if (faddr_q == nssf_pkg::FEAT_DRIVE) begin
				drive_q <= {6'h00, code_q};
			end else begin
				pull_q <= {6'h00, code_q};
			end
		end
	end

	// Byte for the current write beat
	always_comb begin
		byte_d = 8'h00;
		unique case (st_q)
		S_CMD: byte_d = op_q == nssf_pkg::OP_ST70 ? nssf_pkg::CMD_STATUS :
			op_q == nssf_pkg::OP_ST78 ? nssf_pkg::CMD_STATUS_ENH :
			op_q == nssf_pkg::OP_SETF ? nssf_pkg::CMD_SET_FEAT :
			op_q == nssf_pkg::OP_GETF ? nssf_pkg::CMD_GET_FEAT :
			nssf_pkg::CMD_READ_MODE;
		S_ADDR: byte_d = op_q == nssf_pkg::OP_ST78 ? row_q[{idx_q, 3'h0} +: 8] :
			faddr_q;
		// Only P1 bits 1:0 carry the code
		S_DIN: byte_d = idx_q == 2'h0 ? {6'h00, code_q} : 8'h00;
		default: byte_d = 8'h00;
		endcase
	end

	// Pins registered; strobes low in the first part of each beat, read strobe low all through poll
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
				read_strobe_n: 1'b1, io_oe_n: 1'b1, io_out: 8'h00};
		end else begin
			pins_q.ce_n <= st_q == S_IDLE;
			pins_q.cle <= st_q == S_CMD;
			pins_q.ale <= st_q == S_ADDR;
			pins_q.we_n <= !((st_q == S_CMD || st_q == S_ADDR || st_q == S_DIN) &&
				cnt_q < nssf_pkg::WL_CYC);
			pins_q.read_strobe_n <= !(st_q == S_POLL ||
				(st_q == S_DOUT && cnt_q < nssf_pkg::WL_CYC));
			pins_q.io_oe_n <= !(st_q == S_CMD || st_q == S_ADDR || st_q == S_DIN);
			pins_q.io_out <= byte_d;
		end
	end
	assign pins = pins_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	logic [1:0] ale_n_q;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ale_n_q <= 2'h0;
		end else if (start) begin
			ale_n_q <= 2'h0;
		end else if (pins_q.ale && $rose(pins_q.we_n)) begin
			ale_n_q <= ale_n_q + 2'h1;
		end
	end

	sequence s_st_start;
		start && wr_hit && op_w == 3'(nssf_pkg::OP_ST78);
	endsequence
	sequence s_addr_done;
		st_q == S_ADDR ##1 st_q == S_WAIT;
	endsequence

	a_no_bus_fight: assert property (!pins_q.read_strobe_n |-> pins_q.io_oe_n)
		else $error("data driven while reading");
	a_cle_ale_excl: assert property (!(pins_q.cle && pins_q.ale))
		else $error("cle and ale together");
	a_reserved_zero: assert property ($fell(pins_q.we_n) && !pins_q.cle &&
		!pins_q.ale |-> pins_q.io_out[7:2] == 6'h00)
		else $error("reserved parameter bits nonzero");
	a_enh_three_rows: assert property (s_addr_done ##0 op_q == nssf_pkg::OP_ST78
		##2 1'b1 |-> ale_n_q == 2'h3)
		else $error("enhanced status row count wrong");
	a_wait_ready: assert property (st_q == S_BUSY && !rb_s2_q |=> st_q == S_BUSY)
		else $error("left busy wait early");
	a_refuse_plain: assert property (wr_hit && waddr == nssf_pkg::REG_CTRL &&
		st_q == S_IDLE && op_w == 3'(nssf_pkg::OP_ST70) &&
		axi_req.wdata[nssf_pkg::CTRL_MULTI] |=> st_q == S_IDLE && err_q)
		else $error("plain status allowed on multi-die");
	a_refuse_otp: assert property (wr_hit && waddr == nssf_pkg::REG_CTRL &&
		op_w == 3'(nssf_pkg::OP_ST78) && axi_req.wdata[nssf_pkg::CTRL_OTP]
		|=> !$rose(st_q == S_CMD))
		else $error("enhanced status sent in OTP mode");
	a_status_take: assert property (st_q == S_DOUT && is_st &&
		cnt_q == nssf_pkg::CAP_CYC |=> sr_q == $past(io_s2_q))
		else $error("status byte not captured");
	a_poll_live: assert property (st_q == S_POLL ##1 st_q == S_POLL
		|-> !pins_q.read_strobe_n && !pins_q.ce_n)
		else $error("read strobe not held in poll");
	a_shadow_cause: assert property ($changed(drive_q) || $changed(pull_q)
		|-> $past(st_q) == S_BUSY && $past(op_q) == nssf_pkg::OP_SETF)
		else $error("strength shadow changed without set");
	a_enh_starts: assert property (s_st_start |=> st_q == S_CMD ##[1:20]
		st_q == S_ADDR)
		else $error("enhanced status did not reach address");
endmodule

// ---- verif/nssf_nand_model.sv ----
// Behavioural NAND target: two dies, two planes, status and strengths.
// Assumes host pins per nssf_pkg; rb_n has a board pull-up.
`timescale 1ns/100ps
module nssf_nand_model #(
	parameter int FEAT_NS = 2000 // Feature update time, plain default
) (
	input wire nssf_pkg::nssf_pins_t pins, // Host pin outputs
	output wire logic [7:0] io_in, // Data lines towards host
	output wire logic rb_n // Ready/busy, low busy
);
	// --------------------------------------------------------------
	// Target state
	// --------------------------------------------------------------
	logic [7:0] last_cmd = 8'h00, feat_addr = 8'h00, last_io = 8'h00;
	logic [7:0] drive_q = 8'h00, pull_q = 8'h00, row0 = 8'h00;
	logic [7:0] pbyte [4] = '{default: 8'h00};
	logic [1:0] fail_q [2][2] = '{default: 2'b00};
	logic [1:0] die_busy = 2'b00;
	logic die_q = 1'b0, plane_q = 1'b0, stat_mode = 1'b0, feat_busy = 1'b0;
	int nab = 0, nd = 0, rd_idx = 0, ncmd = 0, viol = 0;
	wire drv = !pins.ce_n && !pins.read_strobe_n;
	// per die status, fail bits per plane
	wire [7:0] stat = {1'b1, !die_busy[die_q], !die_busy[die_q], 3'b000,
		fail_q[die_q][plane_q]};
	wire [7:0] feat = (feat_addr == 8'h80) ? drive_q : pull_q;
	wire [7:0] out_val = stat_mode ? stat : (rd_idx == 0 ? feat : 8'h00);

	// Busy is timed in real time; the pins have no clock
	task automatic busy_for(input logic d, input int ns, input logic f);
		fork begin
			die_busy[d] = 1'b1;
			feat_busy = f;
			#(ns);
			die_busy[d] = 1'b0;
			feat_busy = 1'b0;
		end join_none
	endtask

	// --------------------------------------------------------------
	// Write strobe decode
	// --------------------------------------------------------------
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.cle) begin
			if (feat_busy && pins.io_out != 8'h70) viol++;
			last_cmd = pins.io_out;
			ncmd++;
			nab = 0;
			nd = 0;
			rd_idx = 0;
			stat_mode = (last_cmd == 8'h70 || last_cmd == 8'h78);
		end else if (!pins.ce_n && pins.ale) begin
			// three row bytes pick die and plane
			if (last_cmd == 8'h78) begin
				if (nab == 0) row0 = pins.io_out;
				if (nab == 2) die_q = pins.io_out[0];
				if (nab == 2) plane_q = row0[6];
				nab++;
			end else begin
				feat_addr = pins.io_out;
				if (last_cmd == 8'hEE) busy_for(die_q, FEAT_NS, 1'b1);
			end
		end else if (!pins.ce_n && last_cmd == 8'hEF && nd < 4) begin
			pbyte[nd] = pins.io_out;
			nd++;
			if (nd == 4 && feat_addr == 8'h80) drive_q = pbyte[0];
			if (nd == 4 && feat_addr == 8'h81) pull_q = pbyte[0];
			if (nd == 4) busy_for(die_q, FEAT_NS, 1'b1);
		end
	end

	// live status; released lines show the inverse of last value
	assign io_in = drv ? out_val : ~last_io;
	always @(posedge pins.read_strobe_n) begin
		last_io = out_val;
		if (last_cmd == 8'hEE) rd_idx++;
	end
	assign rb_n = !(|die_busy);
endmodule

// ---- verif/nssf_host_tb_top.sv ----
// Self-checking bench for the NAND status and strength host.
// Assumes nssf_nand_model stands on the pins; AXI4-Lite driven here.
`timescale 1ns/100ps
module nssf_host_tb_top;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	nssf_pkg::nssf_axi_req_t axi_req = '0;
	nssf_pkg::nssf_axi_rsp_t axi_rsp;
	nssf_pkg::nssf_pins_t pins;
	wire [7:0] io_in;
	wire rb_n;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [1:0] resp;
	logic [31:0] rd;

	always #5 core_clk = ~core_clk;

	nssf_host uut (.core_clk(core_clk), .arst_n(arst_n), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .pins(pins), .io_in(io_in), .rb_n(rb_n));
	nssf_nand_model #(.FEAT_NS(2000)) flash (.pins(pins), .io_in(io_in),
		.rb_n(rb_n));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic finish_test();
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, far above the few thousand cycles expected
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 50000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask

	// Nonblocking drives after each rising edge keep a valid from racing the host's sample
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= {24'h000000, a};
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
		end while (axi_rsp.bvalid !== 1'b1);
		resp = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= {24'h000000, a};
		axi_req.rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
		end while (axi_rsp.rvalid !== 1'b1);
		rd = axi_rsp.rdata;
		resp = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
		@(posedge core_clk);
	endtask

	// Start an operation and wait for the busy flag to drop
	task automatic run_op(input logic [31:0] ctrl);
		axi_wr(nssf_pkg::REG_CTRL, ctrl);
		do axi_rd(nssf_pkg::REG_STAT); while (rd[0] !== 1'b0);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		axi_rd(nssf_pkg::REG_SHADOW);
		chk(rd, 32'h00000000, "strength after reset");
		axi_rd(8'h18);
		chk({rd[29:0], resp}, {30'h0, nssf_pkg::RESP_SLVERR}, "unmapped read");
		axi_wr(8'h06, 32'h00000000);
		chk({30'h0, resp}, {30'h0, nssf_pkg::RESP_SLVERR}, "unaligned write");
	endtask

	task automatic t_status70();
		run_op(32'h00000000);
		chk({24'h0, rd[15:8]}, 32'h000000E0, "ready status");
		chk({30'h0, rd[2:1]}, 32'h00000002, "rb and err");
		chk({24'h0, flash.last_cmd}, 32'h00000070, "status cmd");
	endtask

	// Descending codes show that one feature leaves the other alone
	task automatic t_features();
		logic [15:0] sh;
		sh = 16'h0000;
		for (int c = 3; c >= 0; c--) begin
			for (int f = 0; f < 2; f++) begin
				axi_wr(nssf_pkg::REG_FEAT, {22'h0, c[1:0], 7'h40, f[0]});
				run_op(32'h00000002);
				if (f == 0) sh[7:0] = 8'(c);
				else sh[15:8] = 8'(c);
				chk({31'h0, rb_n}, 32'h1, "done before update");
				chk({flash.pbyte[3], flash.pbyte[2], flash.pbyte[1],
					flash.pbyte[0]}, {30'h0, c[1:0]}, "params");
				axi_rd(nssf_pkg::REG_SHADOW);
				chk(rd, {16'h0, sh}, "strength shadow");
				run_op(32'h00000003);
				axi_rd(nssf_pkg::REG_PDATA);
				chk(rd, {30'h0, c[1:0]}, "get feature");
			end
		end
	endtask

	// Die 1 busy until the final live poll; 70h then reports the last selected die
	task automatic t_status78();
		flash.fail_q[1][1] = 2'b11;
		flash.busy_for(1'b1, 8000, 1'b0);
		axi_wr(nssf_pkg::REG_ROW, 32'h00000040);
		run_op(32'h00000001);
		chk({24'h0, rd[15:8]}, 32'h000000E0, "die 0 apart");
		axi_wr(nssf_pkg::REG_ROW, 32'h00010000);
		run_op(32'h00000001);
		chk({24'h0, rd[15:8]}, 32'h00000080, "die 1 plane 0");
		axi_wr(nssf_pkg::REG_ROW, 32'h00010040);
		run_op(32'h00000001);
		chk({24'h0, rd[15:8]}, 32'h00000083, "die 1 plane 1");
		run_op(32'h00000000);
		chk({24'h0, rd[15:8]}, 32'h00000083, "70h while busy");
		chk({31'h0, rd[2]}, 32'h00000000, "rb pin busy");
		run_op(32'h00000008);
		chk({24'h0, rd[15:8]}, 32'h000000E3, "live poll ends");
	endtask

	task automatic t_readmode();
		run_op(32'h00000004);
		chk({24'h0, flash.last_cmd}, 32'h0, "read mode cmd");
		chk({31'h0, flash.stat_mode}, 32'h0, "status left");
	endtask

	task automatic t_refuse();
		logic [31:0] bad [4] = '{32'h21, 32'h10, 32'h05, 32'h02};
		int n0;
		axi_wr(nssf_pkg::REG_FEAT, 32'h00000090);
		n0 = flash.ncmd;
		foreach (bad[i]) begin
			axi_wr(nssf_pkg::REG_CTRL, bad[i]);
			axi_rd(nssf_pkg::REG_STAT);
			chk({31'h0, rd[1]}, 32'h1, "refused op");
		end
		chk(32'(flash.ncmd - n0), 32'h0, "no pins moved");
		chk(32'(flash.viol), 32'h0, "work during update");
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_status70();
		t_features();
		t_status78();
		t_readmode();
		t_refuse();
		finish_test();
	end
endmodule
